// ===== core/asq_pkg.sv
package asq_pkg;
  localparam int ASQ_NDEV = 4;
  localparam int ASQ_NCH = 8;
  localparam int ASQ_AW = 12;
  // Register byte offsets
  localparam logic [11:0] ASQ_CTRL_OFS = 12'h120;
  localparam logic [11:0] ASQ_STAT_OFS = 12'h124;
  localparam logic [11:0] ASQ_MASK_OFS = 12'h128;
  localparam logic [11:0] ASQ_CHAN_OFS = 12'h12c;
  localparam logic [11:0] ASQ_RATE_OFS = 12'h130;
  localparam logic [11:0] ASQ_COUNT_OFS = 12'h134;
  localparam logic [11:0] ASQ_FRAME_OFS = 12'h138;
  localparam logic [11:0] ASQ_DLEN_OFS = 12'h13c;
  localparam logic [11:0] ASQ_DSTB_OFS = 12'h140;
  // Control register fields
  localparam int ASQ_B_IU_ENA = 0;
  localparam int ASQ_B_IU_RST = 1;
  localparam int ASQ_B_IU_MODE = 2;
  localparam int ASQ_B_CONV_START = 3;
  localparam int ASQ_B_CLK_SRC = 5;
  localparam int ASQ_B_QUEUE_CLR = 8;
  localparam int ASQ_B_DMA_ENA = 16;
  localparam int ASQ_B_DMA_RST = 17;
  localparam int ASQ_B_STAT_ENA = 18;
  localparam logic [31:0] ASQ_CTRL_RW_MASK = 32'h0005_0025;
  localparam logic [31:0] ASQ_CTRL_RESET = 32'h0000_0000;
  // Channel register fields: channel enables low, device assignment above
  localparam int ASQ_CHAN_DEV_LSB = 8;
  // Interrupt status bits
  localparam int ASQ_I_OVERRUN = 0;
  localparam int ASQ_I_BLOCK_DONE = 1;
  localparam int ASQ_I_DMA_DONE = 2;
  localparam int ASQ_I_DMA_ERR = 3;
  localparam int ASQ_NIRQ = 4;
  localparam logic [15:0] ASQ_RATE_RESET = 16'h0064;
  localparam logic [15:0] ASQ_COUNT_RESET = 16'h0001;
endpackage : asq_pkg

// ===== core/asq_sync.sv
`timescale 1ns/1ps
`default_nettype none
module asq_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);
  logic meta;
  logic next_meta;
  logic next_dout;

  always_comb begin
    next_meta = din;
    next_dout = meta;
    if (!resetn) begin
      next_meta = 1'b0;
      next_dout = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    meta <= next_meta;
    dout <= next_dout;
  end
endmodule : asq_sync
`default_nettype wire

// ===== core/asq_ticker.sv
`timescale 1ns/1ps
`default_nettype none
module asq_ticker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [15:0] period,
  output logic tick
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic next_tick;

  // A period of zero behaves as one cycle
  always_comb begin
    next_count = count + 16'h0001;
    next_tick = 1'b0;
    if (!resetn || !run) begin
      next_count = 16'h0000;
    end else if (count + 16'h0001 >= period) begin
      next_count = 16'h0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    count <= next_count;
    tick <= next_tick;
  end
endmodule : asq_ticker
`default_nettype wire

// ===== core/asq_control.sv
// Summary of operation
// - Each conversion event converts enabled channels of assigned devices, starting at channel 0.
// - Channels 0 to 7 are walked one per cycle; a disabled channel takes its cycle with no strobe.
// - All assigned devices sample the same channel index in the same cycle.
// - Each device may be assigned or not; only assigned devices sample.
// - Conversion events recur at a software-set rate.
// - Normal mode: one block of equally spaced conversions per start command.
// - Frame mode: one frame per frame trigger; frames may repeat at an interval.
// - With status enable set, a status word is written after each buffer end.
// - Writing 1 to the transfer reset bit resets the engine; bit self-clears.
// - With engine enabled, writing the buffer length starts a transfer.
// - Clearing the enable mid-transfer lets that transfer finish first.
// - A transfer error halts the engine until software steps in.
// - The engine is held in reset while its enable is 0 and no transfer is open.
// - Writing 1 to the queue clear bit empties the sample queue; self-clears.
// - Setting the start bit starts a normal-mode process; bit self-clears.
// - Input unit still busy when an event falls due stops conversions, flags error.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module asq_control
  import asq_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic conv_clk_ext,
  input wire logic frame_trigger,
  input wire logic unit_busy,
  output logic conv_event,
  output logic [ASQ_NDEV-1:0] sample_strobe,
  output logic [2:0] sample_channel,
  output logic unit_reset,
  output logic sample_queue_clear,
  input wire logic buffer_done,
  input wire logic transfer_error,
  output logic transfer_engine_reset,
  output logic transfer_start,
  output logic [31:0] transfer_length,
  output logic status_word_write,
  output logic [31:0] status_base
);
  typedef enum logic [1:0] {ASQ_S_IDLE, ASQ_S_ARMED, ASQ_S_WALK, ASQ_S_HALT} asq_seq_t;
  typedef enum logic [1:0] {ASQ_D_IDLE, ASQ_D_BUSY, ASQ_D_STAT, ASQ_D_ERR} asq_dma_t;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Register state
  logic [31:0] ctrl, next_ctrl;
  logic [ASQ_NIRQ-1:0] stat, next_stat, mask, next_mask;
  logic [15:0] chan_cfg, next_chan_cfg;
  logic [15:0] rate, next_rate, count_cfg, next_count_cfg, frame_ivl, next_frame_ivl;
  logic [31:0] next_transfer_length, next_status_base, next_rdata;
  logic next_irq;
  asq_dma_t dma, next_dma;

  logic wr_ctrl;
  logic start_p, unit_rst_p, qclr_p, dma_rst_p;
  logic [ASQ_NIRQ-1:0] events;
  logic dlen_write;

  assign wr_ctrl = wr && hit(addr, ASQ_CTRL_OFS);
  assign start_p = wr_ctrl && wdata[ASQ_B_CONV_START];
  assign unit_rst_p = wr_ctrl && wdata[ASQ_B_IU_RST];
  assign qclr_p = wr_ctrl && wdata[ASQ_B_QUEUE_CLR];
  assign dma_rst_p = wr_ctrl && wdata[ASQ_B_DMA_RST];
  assign dlen_write = wr && hit(addr, ASQ_DLEN_OFS);

  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_chan_cfg = chan_cfg;
    next_rate = rate;
    next_count_cfg = count_cfg;
    next_frame_ivl = frame_ivl;
    next_transfer_length = transfer_length;
    next_status_base = status_base;
    next_rdata = 32'h0000_0000;
    next_stat = stat;
    if (wr) begin
      unique case (addr)
        ASQ_CTRL_OFS: next_ctrl = wdata & ASQ_CTRL_RW_MASK;
        ASQ_MASK_OFS: next_mask = wdata[ASQ_NIRQ-1:0];
        ASQ_CHAN_OFS: next_chan_cfg = wdata[15:0];
        ASQ_RATE_OFS: next_rate = wdata[15:0];
        ASQ_COUNT_OFS: next_count_cfg = wdata[15:0];
        ASQ_FRAME_OFS: next_frame_ivl = wdata[15:0];
        ASQ_DLEN_OFS: next_transfer_length = wdata;
        ASQ_DSTB_OFS: next_status_base = wdata;
        default: next_ctrl = ctrl;
      endcase
    end
    if (rd) begin
      unique case (addr)
        ASQ_CTRL_OFS: next_rdata = ctrl;
        ASQ_STAT_OFS: next_rdata = {28'h000_0000, stat};
        ASQ_MASK_OFS: next_rdata = {28'h000_0000, mask};
        ASQ_CHAN_OFS: next_rdata = {16'h0000, chan_cfg};
        ASQ_RATE_OFS: next_rdata = {16'h0000, rate};
        ASQ_COUNT_OFS: next_rdata = {16'h0000, count_cfg};
        ASQ_FRAME_OFS: next_rdata = {16'h0000, frame_ivl};
        ASQ_DLEN_OFS: next_rdata = transfer_length;
        ASQ_DSTB_OFS: next_rdata = status_base;
        default: next_rdata = 32'h0000_0000;
      endcase
      if (hit(addr, ASQ_STAT_OFS)) begin
        next_stat = '0;
      end
    end
    // New events win over a clearing read
    next_stat = next_stat | events;
    next_irq = |(next_stat & next_mask);
    if (!resetn) begin
      next_ctrl = ASQ_CTRL_RESET;
      next_mask = '0;
      next_chan_cfg = 16'h0000;
      next_rate = ASQ_RATE_RESET;
      next_count_cfg = ASQ_COUNT_RESET;
      next_frame_ivl = 16'h0000;
      next_transfer_length = 32'h0000_0000;
      next_status_base = 32'h0000_0000;
      next_rdata = 32'h0000_0000;
      next_stat = '0;
      next_irq = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    ctrl <= next_ctrl;
    mask <= next_mask;
    chan_cfg <= next_chan_cfg;
    rate <= next_rate;
    count_cfg <= next_count_cfg;
    frame_ivl <= next_frame_ivl;
    transfer_length <= next_transfer_length;
    status_base <= next_status_base;
    rdata <= next_rdata;
    stat <= next_stat;
    irq <= next_irq;
  end

  // Pin inputs
  logic conv_clk_s, trig_s, busy_s, conv_clk_d, trig_d;
  asq_sync u_sync_clk (.clk(clk), .resetn(resetn), .din(conv_clk_ext), .dout(conv_clk_s));
  asq_sync u_sync_trig (.clk(clk), .resetn(resetn), .din(frame_trigger), .dout(trig_s));
  asq_sync u_sync_busy (.clk(clk), .resetn(resetn), .din(unit_busy), .dout(busy_s));

  // Conversion rate and frame interval
  logic unit_on, rate_tick, frame_tick, tick, trig_rise, frame_mode;
  assign unit_on = ctrl[ASQ_B_IU_ENA] && !unit_rst_p;
  assign frame_mode = ctrl[ASQ_B_IU_MODE];
  asq_ticker u_rate (.clk(clk), .resetn(resetn), .run(unit_on), .period(rate),
    .tick(rate_tick));
  asq_ticker u_frame (.clk(clk), .resetn(resetn),
    .run(unit_on && frame_mode && frame_ivl != 16'h0000), .period(frame_ivl),
    .tick(frame_tick));
  assign tick = ctrl[ASQ_B_CLK_SRC] ? (conv_clk_s && !conv_clk_d) : rate_tick;
  assign trig_rise = trig_s && !trig_d;

  // Sequencer
  asq_seq_t seq, next_seq;
  logic [2:0] ch, next_ch;
  logic [15:0] remaining, next_remaining;
  logic [ASQ_NDEV-1:0] next_sample_strobe;
  logic [2:0] next_sample_channel;
  logic next_conv_event, next_unit_reset, next_qclr;
  logic [ASQ_NDEV-1:0] dev_assign;
  logic [ASQ_NCH-1:0] ch_enable;
  assign dev_assign = chan_cfg[ASQ_CHAN_DEV_LSB +: ASQ_NDEV];
  assign ch_enable = chan_cfg[ASQ_NCH-1:0];

  always_comb begin
    next_seq = seq;
    next_ch = ch;
    next_remaining = remaining;
    next_sample_strobe = '0;
    next_sample_channel = sample_channel;
    next_conv_event = 1'b0;
    next_unit_reset = !unit_on;
    next_qclr = qclr_p;
    events = '0;
    unique case (seq)
      ASQ_S_IDLE: begin
        if ((!frame_mode && start_p) || (frame_mode && (trig_rise || frame_tick))) begin
          next_remaining = count_cfg;
          next_seq = ASQ_S_ARMED;
        end
      end
      ASQ_S_ARMED: begin
        if (remaining == 16'h0000) begin
          next_seq = ASQ_S_IDLE;
          events[ASQ_I_BLOCK_DONE] = 1'b1;
        end else if (tick && busy_s) begin
          next_seq = ASQ_S_HALT;
          events[ASQ_I_OVERRUN] = 1'b1;
        end else if (tick) begin
          next_ch = 3'h0;
          next_conv_event = 1'b1;
          next_seq = ASQ_S_WALK;
        end
      end
      ASQ_S_WALK: begin
        next_sample_strobe = ch_enable[ch] ? dev_assign : '0;
        next_sample_channel = ch;
        next_ch = ch + 3'h1;
        if (tick) begin
          next_seq = ASQ_S_HALT;
          events[ASQ_I_OVERRUN] = 1'b1;
        end else if (ch == 3'h7) begin
          next_remaining = remaining - 16'h0001;
          next_seq = ASQ_S_ARMED;
        end
      end
      ASQ_S_HALT: next_seq = ASQ_S_HALT;
    endcase
    if (!unit_on) begin
      next_seq = ASQ_S_IDLE;
      next_sample_strobe = '0;
    end
    events[ASQ_I_DMA_DONE] = dma == ASQ_D_BUSY && buffer_done;
    events[ASQ_I_DMA_ERR] = dma == ASQ_D_BUSY && transfer_error;
    if (!resetn) begin
      next_seq = ASQ_S_IDLE;
      next_ch = 3'h0;
      next_remaining = 16'h0000;
      next_sample_strobe = '0;
      next_sample_channel = 3'h0;
      next_conv_event = 1'b0;
      next_unit_reset = 1'b1;
      next_qclr = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    seq <= next_seq;
    ch <= next_ch;
    remaining <= next_remaining;
    sample_strobe <= next_sample_strobe;
    sample_channel <= next_sample_channel;
    conv_event <= next_conv_event;
    unit_reset <= next_unit_reset;
    sample_queue_clear <= next_qclr;
    conv_clk_d <= resetn ? conv_clk_s : 1'b0;
    trig_d <= resetn ? trig_s : 1'b0;
  end

  // Transfer engine control
  logic hold, next_transfer_start, next_status_word_write;
  // Disabled engine is held in reset, but only once an open transfer has ended
  assign hold = dma_rst_p || (!ctrl[ASQ_B_DMA_ENA] && dma != ASQ_D_BUSY);

  always_comb begin
    next_dma = dma;
    next_transfer_start = 1'b0;
    next_status_word_write = 1'b0;
    unique case (dma)
      ASQ_D_IDLE: begin
        if (dlen_write && ctrl[ASQ_B_DMA_ENA]) begin
          next_dma = ASQ_D_BUSY;
          next_transfer_start = 1'b1;
        end
      end
      ASQ_D_BUSY: begin
        if (transfer_error) begin
          next_dma = ASQ_D_ERR;
        end else if (buffer_done) begin
          next_dma = ctrl[ASQ_B_STAT_ENA] ? ASQ_D_STAT : ASQ_D_IDLE;
          next_status_word_write = ctrl[ASQ_B_STAT_ENA];
        end
      end
      ASQ_D_STAT: next_dma = ASQ_D_IDLE;
      ASQ_D_ERR: next_dma = ASQ_D_ERR;
    endcase
    if (hold) begin
      next_dma = ASQ_D_IDLE;
      next_transfer_start = 1'b0;
      next_status_word_write = 1'b0;
    end
    if (!resetn) begin
      next_dma = ASQ_D_IDLE;
      next_transfer_start = 1'b0;
      next_status_word_write = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    dma <= next_dma;
    transfer_start <= next_transfer_start;
    status_word_write <= next_status_word_write;
    transfer_engine_reset <= resetn ? hold : 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_walk_begin;
    seq == ASQ_S_ARMED && unit_on && remaining != 16'h0000 && tick && !busy_s;
  endsequence
  sequence s_walk_first;
    seq == ASQ_S_WALK && ch == 3'h0;
  endsequence

  a_walk_from_zero: assert property (s_walk_begin |=> s_walk_first)
    else $error("walk did not start at channel 0");
  a_walk_fast: assert property ((s_walk_begin ##1 s_walk_first) |-> ##[1:8] seq != ASQ_S_WALK)
    else $error("channel walk took too long");
  a_lockstep_devices: assert property (sample_strobe != '0 |->
    sample_strobe == $past(dev_assign))
    else $error("devices not sampled together");
  a_start_arms: assert property (seq == ASQ_S_IDLE && unit_on && !frame_mode && start_p |=> seq == ASQ_S_ARMED)
    else $error("start command ignored");
  a_overrun_halts: assert property (seq == ASQ_S_WALK && unit_on && tick |=> seq == ASQ_S_HALT && stat[ASQ_I_OVERRUN])
    else $error("overrun not flagged");
  a_transfer_start: assert property (dma == ASQ_D_IDLE && dlen_write && ctrl[ASQ_B_DMA_ENA] && !dma_rst_p |=> transfer_start && dma == ASQ_D_BUSY)
    else $error("transfer not started");
  a_status_word: assert property (dma == ASQ_D_BUSY && buffer_done && !transfer_error && !hold |=> status_word_write == $past(ctrl[ASQ_B_STAT_ENA]))
    else $error("status word mismatch");
  a_finish_transfer: assert property (dma == ASQ_D_BUSY && !dma_rst_p && !buffer_done && !transfer_error |=> dma == ASQ_D_BUSY)
    else $error("transfer cut short");
  a_error_halts: assert property (dma == ASQ_D_ERR && !hold |=> dma == ASQ_D_ERR)
    else $error("engine left error state");
  a_engine_held: assert property (!ctrl[ASQ_B_DMA_ENA] && dma != ASQ_D_BUSY |=> transfer_engine_reset && !transfer_start)
    else $error("disabled engine not held");
  a_engine_reset: assert property (dma_rst_p |=> transfer_engine_reset && !ctrl[ASQ_B_DMA_RST])
    else $error("engine reset bit misbehaved");
  a_queue_clear: assert property (qclr_p |=> sample_queue_clear && !ctrl[ASQ_B_QUEUE_CLR])
    else $error("queue clear missing");
  a_ctrl_reserved: assert property (rd && hit(addr, ASQ_CTRL_OFS) |=> (rdata & ~ASQ_CTRL_RW_MASK) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
endmodule : asq_control
`default_nettype wire

// ===== testbench/asq_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module asq_far_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic conv_event,
  input wire logic transfer_start,
  input wire logic [7:0] busy_len,
  input wire logic err_mode,
  output logic unit_busy,
  output logic buffer_done,
  output logic transfer_error
);
  int bcnt;
  int dcnt;
  // Input unit stays busy busy_len cycles per event; a transfer ends 6 cycles after start
  always_ff @(posedge clk) begin
    buffer_done <= 1'b0;
    transfer_error <= 1'b0;
    if (!resetn) begin
      bcnt <= 0;
      dcnt <= 0;
      unit_busy <= 1'b0;
    end else begin
      if (conv_event) bcnt <= int'(busy_len);
      else if (bcnt > 0) bcnt <= bcnt - 1;
      unit_busy <= conv_event || bcnt > 1;
      if (transfer_start) dcnt <= 6;
      else if (dcnt > 0) dcnt <= dcnt - 1;
      if (dcnt == 1) begin
        buffer_done <= !err_mode;
        transfer_error <= err_mode;
      end
    end
  end
endmodule : asq_far_model
`default_nettype wire

// ===== testbench/asq_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module asq_control_tb_top;
  import asq_pkg::*;
  localparam int RATE = 20;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic conv_clk_ext;
  logic frame_trigger;
  logic [7:0] busy_len;
  logic err_mode;
  logic [31:0] rdata;
  logic irq;
  logic unit_busy;
  logic conv_event;
  logic [ASQ_NDEV-1:0] sample_strobe;
  logic [2:0] sample_channel;
  logic unit_reset;
  logic sample_queue_clear;
  logic buffer_done;
  logic transfer_error;
  logic transfer_engine_reset;
  logic transfer_start;
  logic [31:0] transfer_length;
  logic status_word_write;
  logic [31:0] status_base;
  logic [31:0] rv;
  logic [31:0] cfg;
  logic [31:0] len;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed = 4;
  int n_ev = 0;
  int n_xs = 0;
  int n_sww = 0;
  int n_qc = 0;
  int n_er = 0;
  int last = 0;
  int ph = 0;

  always #50 clk = ~clk;

  asq_control u_dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .conv_clk_ext(conv_clk_ext), .frame_trigger(frame_trigger),
    .unit_busy(unit_busy), .conv_event(conv_event), .sample_strobe(sample_strobe),
    .sample_channel(sample_channel), .unit_reset(unit_reset),
    .sample_queue_clear(sample_queue_clear), .buffer_done(buffer_done),
    .transfer_error(transfer_error), .transfer_engine_reset(transfer_engine_reset),
    .transfer_start(transfer_start), .transfer_length(transfer_length),
    .status_word_write(status_word_write), .status_base(status_base));

  asq_far_model u_far (.clk(clk), .resetn(resetn), .conv_event(conv_event),
    .transfer_start(transfer_start), .busy_len(busy_len), .err_mode(err_mode),
    .unit_busy(unit_busy), .buffer_done(buffer_done), .transfer_error(transfer_error));

  task automatic test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [3:0] exp_strobe(input logic [31:0] c, input int ch);
    return c[ch] ? c[11:8] : 4'h0;
  endfunction : exp_strobe

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wreg

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
    chk(what, rv, exp);
  endtask : rchk

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : waitc

  // Event counters, strobe walk and hang guard
  always @(posedge clk) begin
    if (cycles > 20000) begin
      failures++;
      test_done();
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (ph > 0) begin
      chk("sample_strobe", 32'(sample_strobe), 32'(exp_strobe(cfg, ph - 1)));
      if (sample_strobe !== 4'h0) chk("sample_channel", 32'(sample_channel), ph - 1);
    end
    ph = (conv_event === 1'b1) ? 1 : ((ph > 0 && ph < 8) ? ph + 1 : 0);
    if (conv_event === 1'b1) begin
      // Spacing holds only inside a block of three conversions
      if (n_ev % 3 != 0) chk("event spacing", cycles - last, RATE);
      last = cycles;
      n_ev++;
    end
    if (transfer_start === 1'b1) n_xs++;
    if (status_word_write === 1'b1) n_sww++;
    if (sample_queue_clear === 1'b1) n_qc++;
    if (transfer_engine_reset === 1'b1) n_er++;
  end

  initial begin
    addr = 12'h000;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    conv_clk_ext = 1'b0;
    frame_trigger = 1'b0;
    busy_len = 8'h04;
    err_mode = 1'b0;
    cfg = 32'h0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk("unit_reset", 32'(unit_reset), 32'h1);
    chk("engine reset", 32'(transfer_engine_reset), 32'h1);
    rchk("ctrl reset", ASQ_CTRL_OFS, ASQ_CTRL_RESET);
    rchk("rate reset", ASQ_RATE_OFS, 32'(ASQ_RATE_RESET));
    rchk("count reset", ASQ_COUNT_OFS, 32'(ASQ_COUNT_RESET));
    rchk("unmapped", 12'h200, 32'h0);
    wreg(ASQ_CTRL_OFS, 32'hffff_ffff);
    rchk("ctrl reserved", ASQ_CTRL_OFS, ASQ_CTRL_RW_MASK);
    wreg(ASQ_CTRL_OFS, 32'h0);
    rchk("status drain", ASQ_STAT_OFS, 32'h0);
    $display("test registers done");
    wreg(ASQ_RATE_OFS, 32'(RATE));
    wreg(ASQ_COUNT_OFS, 32'h3);
    wreg(ASQ_MASK_OFS, 32'h2);
    wreg(ASQ_CTRL_OFS, 32'h1);
    waitc(2);
    chk("unit enabled", 32'(unit_reset), 32'h0);
    for (int k = 0; k < 4; k++) begin
      cfg = (k == 0) ? 32'h0f01 : (k == 1) ? 32'h0080 : 32'($random(seed)) & 32'h0fff;
      wreg(ASQ_CHAN_OFS, cfg);
      rchk("channel config", ASQ_CHAN_OFS, cfg);
      n_ev = 0;
      wreg(ASQ_CTRL_OFS, 32'h9);
      rchk("start self-clear", ASQ_CTRL_OFS, 32'h1);
      waitc(100);
      chk("events per block", n_ev, 3);
      chk("irq", 32'(irq), 32'h1);
      rchk("block status", ASQ_STAT_OFS, 32'h2);
      waitc(1);
      chk("irq cleared", 32'(irq), 32'h0);
    end
    $display("test normal mode done");
    busy_len = 8'h3c;
    n_ev = 0;
    wreg(ASQ_CTRL_OFS, 32'h9);
    waitc(100);
    chk("events before halt", n_ev, 1);
    rchk("overrun status", ASQ_STAT_OFS, 32'h1);
    busy_len = 8'h04;
    wreg(ASQ_CTRL_OFS, 32'h0);
    // Rate shorter than a walk: tick lands at channel 4, channels 5 to 7 unstrobed
    cfg = 32'h0f01;
    wreg(ASQ_CHAN_OFS, cfg);
    wreg(ASQ_RATE_OFS, 32'h5);
    wreg(ASQ_CTRL_OFS, 32'h1);
    n_ev = 0;
    wreg(ASQ_CTRL_OFS, 32'h9);
    waitc(30);
    chk("walk overrun events", n_ev, 1);
    rchk("walk overrun", ASQ_STAT_OFS, 32'h1);
    wreg(ASQ_RATE_OFS, 32'(RATE));
    wreg(ASQ_CTRL_OFS, 32'h0);
    wreg(ASQ_CTRL_OFS, 32'h5);
    n_ev = 0;
    for (int k = 1; k <= 2; k++) begin
      frame_trigger <= 1'b1;
      waitc(100);
      chk("frame events", n_ev, 3 * k);
      rchk("frame status", ASQ_STAT_OFS, 32'h2);
      frame_trigger <= 1'b0;
      waitc(5);
    end
    wreg(ASQ_CTRL_OFS, 32'h21);
    n_ev = 0;
    wreg(ASQ_CTRL_OFS, 32'h29);
    // Pin clock source: rising edges 20 cycles apart, the fourth falls in idle
    repeat (4) begin
      conv_clk_ext <= 1'b1;
      waitc(10);
      conv_clk_ext <= 1'b0;
      waitc(10);
    end
    chk("pin clock events", n_ev, 3);
    rchk("pin clock status", ASQ_STAT_OFS, 32'h2);
    n_ev = 0;
    wreg(ASQ_FRAME_OFS, 32'h64);
    rchk("frame interval", ASQ_FRAME_OFS, 32'h64);
    wreg(ASQ_CTRL_OFS, 32'h5);
    waitc(280);
    chk("repeated frames", n_ev, 6);
    rchk("repeated frame status", ASQ_STAT_OFS, 32'h2);
    $display("test overrun and frame done");
    n_qc = 0;
    wreg(ASQ_CTRL_OFS, 32'h100);
    waitc(2);
    chk("queue clear pulse", n_qc, 1);
    rchk("queue clear bit", ASQ_CTRL_OFS, 32'h0);
    wreg(ASQ_DLEN_OFS, 32'h40);
    waitc(10);
    chk("start while off", n_xs, 0);
    chk("held in reset", 32'(transfer_engine_reset), 32'h1);
    wreg(ASQ_CTRL_OFS, 32'h50000);
    waitc(2);
    chk("engine released", 32'(transfer_engine_reset), 32'h0);
    len = 32'($random(seed));
    wreg(ASQ_DSTB_OFS, len);
    chk("status base", status_base, len);
    len = 32'($random(seed));
    wreg(ASQ_DLEN_OFS, len);
    waitc(12);
    chk("transfer start", n_xs, 1);
    chk("transfer length", transfer_length, len);
    chk("status word", n_sww, 1);
    rchk("buffer status", ASQ_STAT_OFS, 32'h4);
    wreg(ASQ_CTRL_OFS, 32'h10000);
    wreg(ASQ_DLEN_OFS, 32'h80);
    waitc(12);
    chk("second start", n_xs, 2);
    chk("no status word", n_sww, 1);
    wreg(ASQ_CTRL_OFS, 32'h50000);
    wreg(ASQ_DLEN_OFS, 32'h90);
    wreg(ASQ_CTRL_OFS, 32'h40000);
    waitc(12);
    chk("finish after disable", n_sww, 2);
    chk("reset after finish", 32'(transfer_engine_reset), 32'h1);
    rchk("status drain", ASQ_STAT_OFS, 32'h4);
    err_mode = 1'b1;
    wreg(ASQ_CTRL_OFS, 32'h10000);
    wreg(ASQ_DLEN_OFS, 32'ha0);
    waitc(12);
    rchk("error status", ASQ_STAT_OFS, 32'h8);
    wreg(ASQ_DLEN_OFS, 32'hb0);
    waitc(12);
    chk("halted", n_xs, 4);
    err_mode = 1'b0;
    wreg(ASQ_CTRL_OFS, 32'h0);
    wreg(ASQ_CTRL_OFS, 32'h10000);
    wreg(ASQ_DLEN_OFS, 32'hc0);
    waitc(12);
    chk("recovered", n_xs, 5);
    n_er = 0;
    wreg(ASQ_CTRL_OFS, 32'h30000);
    waitc(3);
    chk("engine reset pulse", 32'(n_er != 0), 32'h1);
    rchk("engine reset bit", ASQ_CTRL_OFS, 32'h10000);
    $display("test transfer engine done");
    test_done();
  end
endmodule : asq_control_tb_top
`default_nettype wire
